// ### design/cahd_defs.vh
// Shared constants for the card host-signal decode block.
`ifndef CAHD_DEFS_VH
`define CAHD_DEFS_VH
// Interface modes.
`define CAHD_MODE_MEM   2'h0
`define CAHD_MODE_IO    2'h1
`define CAHD_MODE_IDE   2'h2
// Register target classes presented to the controller.
`define CAHD_TGT_NONE   2'h0
`define CAHD_TGT_TASK   2'h1
`define CAHD_TGT_CTRL   2'h2
`define CAHD_TGT_ATTR   2'h3
// Lane selection codes.
`define CAHD_LANE_NONE  2'h0
`define CAHD_LANE_LOW   2'h1
`define CAHD_LANE_HIGH  2'h2
`define CAHD_LANE_WORD  2'h3
// Burst state codes.
`define CAHD_ST_IDLE    2'h0
`define CAHD_ST_IN      2'h1
`define CAHD_ST_OUT     2'h2
// Cable-select strap: cycles to wait for the synchroniser, then the done code.
`define CAHD_STRAP_WAIT 2'h2
`define CAHD_STRAP_DONE 2'h3
// FIFO defaults.
`define CAHD_FIFO_WIDTH 16
`define CAHD_FIFO_DEPTH 16
`endif

// ### design/cahd_fifo.v
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cahd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  input  wire             flush
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // =========================================
  // Storage array and pointers.
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Output word is read from the array combinationally at the head pointer.
  always @* begin
    out_data = mem[rd_ptr];
  end
endmodule

// ### design/cahd_host_decode.v
// Host signal decode for a removable flash card: lanes, selects, strobes and Ultra DMA.
// Notes on behaviour
// - Host may drop ready to pause a read; device stops sending meanwhile.
// - During a write burst, capture a word on both strobe edges.
// - Strobe pauses are harmless; capture resumes when edges return.
// - Both card-detect outputs are tied to ground in every mode.
// - With the second card enable active, the odd byte rides the upper lane.
// - First card enable alone picks even or odd byte from address bit zero.
// - Byte steering lets an eight-bit host reach every byte on the low lane.
// - In IDE mode the first chip select picks the task file registers.
// - In IDE mode the second chip select picks alternate status and device control.
// - During DMA acknowledge both chip selects stay idle; transfers are sixteen bits.
// - In IDE mode grounded cable select gives master, open gives slave.
// - In I/O mode, write data is captured on the rising trailing edge.
// - In IDE mode without Ultra DMA, the write strobe acts as in I/O mode.
// - During Ultra DMA, stop from the host ends the current burst.
// - Memory mode reads common memory and attribute space under output enable.
// - I/O mode uses output enable only for attribute space reads.
// - In IDE mode without Ultra DMA, the read strobe acts as in I/O mode.
// - Without an active DMA operation, the acknowledge line is ignored.
`timescale 1ns/1ps
`include "cahd_defs.vh"
module cahd_host_decode #(
  parameter WIDTH = `CAHD_FIFO_WIDTH,
  parameter DEPTH = `CAHD_FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire [1:0]       mode,
  input  wire             dma_active,
  input  wire             udma_active,
  input  wire             udma_dir_in,
  input  wire             card_en1_n,
  input  wire             card_en2_n,
  input  wire             chip_sel0_n,
  input  wire             chip_sel1_n,
  input  wire             reg_sel_n,
  input  wire             addr0,
  input  wire             out_en_n,
  input  wire             io_rd_n,
  input  wire             io_wr_n,
  input  wire             dma_ack_n,
  input  wire             cable_sel_n,
  input  wire             host_ready_n,
  input  wire [15:0]      data_in,
  output reg  [15:0]      data_out,
  output reg  [1:0]       data_oe,
  output wire             card_det1_n,
  output wire             card_det2_n,
  output reg              is_master,
  output reg              wr_pulse,
  output reg  [1:0]       wr_target,
  output reg  [1:0]       wr_lane,
  output reg  [15:0]      wr_data,
  output reg              rd_pulse,
  output reg  [1:0]       rd_target,
  output reg  [1:0]       rd_lane,
  input  wire [15:0]      rd_data,
  input  wire [15:0]      in_burst_data,
  input  wire             in_burst_valid,
  output wire             in_burst_ready,
  output reg              burst_done,
  output wire [WIDTH-1:0] core_data,
  output wire             core_valid,
  input  wire             core_ready,
  output wire             udma_overrun
);
  // =========================================
  // Pin synchronisers: two flops before any logic.
  localparam NS = 27;
  wire [NS-1:0] pin_raw = {card_en1_n, card_en2_n, chip_sel0_n, chip_sel1_n, reg_sel_n, addr0,
                           out_en_n, io_rd_n, io_wr_n, dma_ack_n, cable_sel_n, data_in};
  reg  [NS-1:0] sync1;
  reg  [NS-1:0] sync2;
  reg  [NS-1:0] prev;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= {NS{1'b1}};
      sync2 <= {NS{1'b1}};
      prev  <= {NS{1'b1}};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  // Host ready is a separate pin and is synchronised the same way.
  reg rdy_s1;
  reg rdy_s2;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
    end else begin
      rdy_s1 <= host_ready_n;
      rdy_s2 <= rdy_s1;
    end
  end

  wire        ce1    = ~sync2[26];
  wire        ce2    = ~sync2[25];
  wire        cs0    = ~sync2[24];
  wire        cs1    = ~sync2[23];
  wire        attr   = ~sync2[22];
  wire        a0     = sync2[21];
  wire        oe     = ~sync2[20];
  wire        iord   = ~sync2[19];
  wire        iowr   = ~sync2[18];
  wire        dmack  = ~sync2[17] & dma_active;
  wire        csel   = sync2[16];
  wire [15:0] dbus   = sync2[15:0];
  wire        iowr_rise = sync2[18] & ~prev[18];
  wire        ide    = (mode == `CAHD_MODE_IDE);
  wire        io     = (mode == `CAHD_MODE_IO);
  wire        mem    = (mode == `CAHD_MODE_MEM);

  // Card detect is grounded in every mode.
  assign card_det1_n = 1'b0;
  assign card_det2_n = 1'b0;

  // =========================================
  // Master or slave from cable select, caught once the synchroniser holds the real pin level.
  // Sampling at the first edge would read the reset value of the flops and always give slave.
  reg [1:0] strap_cnt;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt <= 2'h0;
      is_master <= 1'b0;
    end else if (strap_cnt == `CAHD_STRAP_WAIT) begin
      strap_cnt <= `CAHD_STRAP_DONE;
      is_master <= ide & ~csel;
    end else if (strap_cnt != `CAHD_STRAP_DONE) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // =========================================
  // Lane and target decode for the current cycle.
  reg [1:0] lane;
  reg [1:0] tgt;
  reg       sel;
  always @* begin
    lane = `CAHD_LANE_NONE;
    tgt  = `CAHD_TGT_NONE;
    sel  = 1'b0;
    if (ide) begin
      if (dmack) begin
        lane = `CAHD_LANE_WORD;
        sel  = 1'b1;
      end else if (cs0) begin
        tgt  = `CAHD_TGT_TASK;
        lane = `CAHD_LANE_WORD;
        sel  = 1'b1;
      end else if (cs1) begin
        tgt  = `CAHD_TGT_CTRL;
        lane = `CAHD_LANE_WORD;
        sel  = 1'b1;
      end
    end else if (ce1 || ce2) begin
      sel = 1'b1;
      // In I/O mode the register select is also low on plain I/O cycles, so only output enable means attribute space.
      tgt = (attr && (mem || oe)) ? `CAHD_TGT_ATTR : `CAHD_TGT_TASK;
      if (ce1 && ce2) begin
        lane = `CAHD_LANE_WORD;
      end else if (ce2) begin
        lane = `CAHD_LANE_HIGH;
      end else if (a0) begin
        lane = `CAHD_LANE_HIGH;
      end else begin
        lane = `CAHD_LANE_LOW;
      end
    end
  end

  // Read permission per mode.
  wire rd_ok = sel & ~udma_active &
               ((mem & oe) |
                (io & ((oe & attr) | iord)) |
                (ide & iord));
  wire wr_ok = sel & ~udma_active & (io | ide) & iowr_rise;

  // =========================================
  // Register write capture on the trailing edge and read requests.
  reg rd_prev;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pulse  <= 1'b0;
      wr_target <= `CAHD_TGT_NONE;
      wr_lane   <= `CAHD_LANE_NONE;
      wr_data   <= 16'h0000;
      rd_pulse  <= 1'b0;
      rd_target <= `CAHD_TGT_NONE;
      rd_lane   <= `CAHD_LANE_NONE;
      rd_prev   <= 1'b0;
    end else begin
      // Selects are taken from the same synchronised sample in which the strobe rose.
      wr_pulse <= 1'b0;
      if (wr_ok) begin
        wr_pulse  <= 1'b1;
        wr_target <= tgt;
        wr_lane   <= lane;
        // Odd byte on the low lane is moved up for an 8-bit host.
        wr_data   <= (lane == `CAHD_LANE_HIGH && !ce2) ? {dbus[7:0], dbus[7:0]} : dbus;
      end
      rd_prev  <= rd_ok;
      rd_pulse <= rd_ok & ~rd_prev;
      if (rd_ok && !rd_prev) begin
        rd_target <= tgt;
        rd_lane   <= lane;
      end
    end
  end

  // =========================================
  // Read data drive and burst data-in output.
  reg        burst_prev_send;
  wire       burst_send = udma_active & udma_dir_in & ~rdy_s2 & in_burst_valid;
  assign in_burst_ready = udma_active & udma_dir_in & ~rdy_s2;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out        <= 16'h0000;
      data_oe         <= 2'h0;
      burst_prev_send <= 1'b0;
    end else begin
      burst_prev_send <= burst_send;
      if (burst_send) begin
        data_out <= in_burst_data;
        data_oe  <= 2'h3;
      end else if (rd_ok) begin
        if (lane == `CAHD_LANE_HIGH && !ce2) begin
          data_out <= {rd_data[15:8], rd_data[15:8]};
          data_oe  <= 2'h1;
        end else begin
          data_out <= rd_data;
          data_oe  <= lane;
        end
      end else if (!(udma_active && udma_dir_in)) begin
        data_oe  <= 2'h0;
      end
    end
  end

  // =========================================
  // Write burst: both edges of the host strobe latch a word.
  wire hstrobe_edge = udma_active & ~udma_dir_in & (sync2[19] ^ prev[19]);
  wire stop_req     = udma_active & ~sync2[18] & prev[18];
  wire fifo_in_ready;
  reg  overrun;
  assign udma_overrun = overrun;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      burst_done <= 1'b0;
      overrun    <= 1'b0;
    end else begin
      burst_done <= stop_req;
      if (!udma_active) begin
        overrun <= 1'b0;
      end else if (hstrobe_edge && !fifo_in_ready) begin
        overrun <= 1'b1;
      end
    end
  end

  cahd_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_data   (dbus[WIDTH-1:0]),
    .in_valid  (hstrobe_edge),
    .in_ready  (fifo_in_ready),
    .out_data  (core_data),
    .out_valid (core_valid),
    .out_ready (core_ready),
    .flush     (1'b0)
  );
endmodule

// ### verification/cahd_host_decode_asserts.sv
// Port checks for the card host-signal decode block.
`timescale 1ns/1ps
`include "cahd_defs.vh"
module cahd_host_decode_chk #(
  parameter WIDTH = 16
) (
  input wire             ref_clk,
  input wire             resetn,
  input wire [1:0]       mode,
  input wire             udma_active,
  input wire             io_wr_n,
  input wire             host_ready_n,
  input wire             card_det1_n,
  input wire             card_det2_n,
  input wire             is_master,
  input wire             wr_pulse,
  input wire [1:0]       wr_lane,
  input wire             rd_pulse,
  input wire             in_burst_ready,
  input wire             burst_done,
  input wire [WIDTH-1:0] core_data,
  input wire             core_valid,
  input wire             core_ready
);
  // ====
  // Every check samples the core clock and rests in reset.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  property p_det; !card_det1_n && !card_det2_n; endproperty
  a_det: assert property (p_det) else $error("card detect high");
  property p_wr; wr_pulse |-> $past(io_wr_n, 2) && !$past(io_wr_n, 4); endproperty
  a_wr: assert property (p_wr) else $error("write pulse without trailing edge");
  property p_word; wr_pulse && mode == `CAHD_MODE_IDE |-> wr_lane == `CAHD_LANE_WORD; endproperty
  a_word: assert property (p_word) else $error("narrow write in IDE mode");
  property p_quiet; udma_active [*5] |-> !wr_pulse && !rd_pulse; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe decoded in burst");
  property p_stop; udma_active && $fell(io_wr_n) |-> ##[1:6] burst_done; endproperty
  a_stop: assert property (p_stop) else $error("stop did not end burst");
  property p_mstr; $past(resetn, 4) |-> $stable(is_master); endproperty
  a_mstr: assert property (p_mstr) else $error("master strap moved");
  property p_pause; host_ready_n [*3] |-> !in_burst_ready; endproperty
  a_pause: assert property (p_pause) else $error("data-in while host paused");
  property p_hold; core_valid && !core_ready |=> core_valid && $stable(core_data); endproperty
  a_hold: assert property (p_hold) else $error("buffer word lost in stall");
  // Main scenarios seen.
  c_wr: cover property (wr_pulse);
  c_stop: cover property (burst_done);
  c_out: cover property (core_valid && core_ready);
endmodule
bind cahd_host_decode cahd_host_decode_chk #(.WIDTH(WIDTH)) u_cahd_host_decode_chk (.*);

// ### verification/cahd_host_model.sv
// Host controller model for the Ultra DMA strobe, data and ready lines.
`timescale 1ns/1ps
module cahd_host_model (
  input  wire        run,
  input  wire        hready,
  output reg         hstrobe,
  output reg  [15:0] hdata,
  output wire        host_ready_n
);
  reg [7:0] n;
  // Strobe period is 160 ns and stands still between runs; data leads each edge.
  initial begin
    n = 8'h00;
    hstrobe = 1'b1;
    hdata = 16'h0000;
    forever begin
      #40;
      if (run) begin
        hdata = {n, ~n};
        #40;
        hstrobe = ~hstrobe;
        n = n + 8'h01;
      end else begin
        hdata = ~hdata;
        #40;
      end
    end
  end
  // Low ready lets data-in words flow; high pauses them.
  assign host_ready_n = ~hready;
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the card host-signal decode block.
`timescale 1ns/1ps
`include "cahd_defs.vh"
module tb_top;
  reg         ref_clk, resetn, dma_active, udma_active, udma_dir_in, card_en1_n, card_en2_n, f;
  reg         chip_sel0_n, chip_sel1_n, reg_sel_n, addr0, out_en_n, pio_rd_n, io_wr_n, dma_ack_n;
  reg         cable_sel_n, in_burst_valid, core_ready, run, hready, hold;
  reg  [1:0]  mode;
  reg  [3:0]  v;
  reg  [15:0] wdat, rd_data, in_burst_data;
  wire [15:0] data_out, wr_data, core_data, hdata, data_in;
  wire [1:0]  data_oe, wr_target, rd_target;
  wire        is_master, wr_pulse, rd_pulse, in_burst_ready, burst_done, core_valid, udma_overrun;
  wire        hstrobe, host_ready_n, io_rd_n;
  integer     seed, mismatches, compares, cycles, cnt, c0, i, j, k;
  // Burst writes take strobe and data from the host model.
  assign io_rd_n = (udma_active & ~udma_dir_in) ? hstrobe : pio_rd_n;
  assign data_in = udma_active ? hdata : wdat;
  cahd_host_decode u_cahd_host_decode (.*, .rd_lane(), .card_det1_n(), .card_det2_n(), .wr_lane());
  cahd_host_model u_cahd_host_model (.*);
  // Clock, hang limit and a stalling consumer that checks words in order.
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      mismatches = mismatches + 1;
      close_out;
    end
    core_ready <= ~hold & $random(seed);
    if (core_valid && core_ready) begin
      chk("word", {cnt[7:0], ~cnt[7:0]}, core_data);
      cnt = cnt + 1;
    end
  end
  task chk(input [8*9:1] nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("Error %0s expected %h got %h", nm, e, g);
      end
    end
  endtask
  task close_out;
    begin
      if (mismatches == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // One access: strobe low, watch for the pulse, check read lanes, release.
  task acc(input wr, input oe, input hit, input [1:0] tgt);
    reg        seen;
    reg [1:0]  t, eo;
    reg [15:0] d, m;
    begin
      seen = 1'b0;
      @(posedge ref_clk);
      eo = !hit ? 2'h0 : (mode == `CAHD_MODE_IDE) ? 2'h3 : {~card_en2_n, ~card_en1_n};
      m = {{8{eo[1]}}, {8{eo[0]}}};
      wdat <= $random(seed);
      rd_data <= $random(seed);
      if (wr)
        io_wr_n <= 1'b0;
      else if (oe)
        out_en_n <= 1'b0;
      else
        pio_rd_n <= 1'b0;
      for (i = 0; i < 10; i = i + 1) begin
        @(posedge ref_clk);
        if (i == 4)
          io_wr_n <= 1'b1;
        #1;
        if (wr_pulse | rd_pulse) begin
          seen = 1'b1;
          t = wr ? wr_target : rd_target;
          d = wr_data;
        end
      end
      chk("pulse", {15'h0, hit}, {15'h0, seen});
      if (hit && tgt != `CAHD_TGT_NONE)
        chk("target", {14'h0, tgt}, {14'h0, t});
      if (hit && wr)
        chk("wr_data", wdat, d);
      if (!wr) begin
        chk("data_oe", {14'h0, eo}, {14'h0, data_oe});
        chk("data_out", m & ((eo == 2'h1 && addr0) ? {8'h0, rd_data[15:8]} : rd_data), m & data_out);
      end
      {out_en_n, pio_rd_n} <= 2'h3;
      repeat (6) @(posedge ref_clk);
    end
  endtask
  // ====
  // Main sequence.
  initial begin
    {ref_clk, resetn, dma_active, udma_active, udma_dir_in, in_burst_valid, run, hready, hold, addr0} = 10'h0;
    {card_en1_n, card_en2_n, chip_sel0_n, chip_sel1_n, reg_sel_n, out_en_n, pio_rd_n, io_wr_n, dma_ack_n} = 9'h1FF;
    {cable_sel_n, core_ready, mode, wdat, rd_data, in_burst_data} = 52'h0;
    {mismatches, compares, cycles, cnt} = 128'h0;
    seed = 32'hE114;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge ref_clk);
      resetn <= 1'b0;
      mode <= `CAHD_MODE_IDE;
      cable_sel_n <= k[0];
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk("master", {15'h0, ~k[0]}, {15'h0, is_master});
    end
    mode <= `CAHD_MODE_MEM;
    for (j = 0; j < 40; j = j + 1) begin
      v = (j < 16) ? j[3:0] : $random(seed);
      {reg_sel_n, card_en1_n, card_en2_n, addr0} <= v;
      acc(1'b0, 1'b1, ~(v[2] & v[1]), v[3] ? `CAHD_TGT_TASK : `CAHD_TGT_ATTR);
    end
    mode <= `CAHD_MODE_IO;
    {reg_sel_n, card_en1_n, card_en2_n, addr0} <= 4'h0;
    acc(1'b0, 1'b0, 1'b1, `CAHD_TGT_TASK);
    acc(1'b0, 1'b1, 1'b1, `CAHD_TGT_ATTR);
    acc(1'b1, 1'b0, 1'b1, `CAHD_TGT_TASK);
    reg_sel_n <= 1'b1;
    acc(1'b0, 1'b1, 1'b0, `CAHD_TGT_NONE);
    mode <= `CAHD_MODE_IDE;
    chip_sel0_n <= 1'b0;
    acc(1'b1, 1'b0, 1'b1, `CAHD_TGT_TASK);
    acc(1'b0, 1'b0, 1'b1, `CAHD_TGT_TASK);
    {chip_sel0_n, chip_sel1_n} <= 2'h2;
    acc(1'b1, 1'b0, 1'b1, `CAHD_TGT_CTRL);
    {chip_sel1_n, dma_ack_n} <= 2'h2;
    acc(1'b1, 1'b0, 1'b0, `CAHD_TGT_NONE);
    dma_active <= 1'b1;
    acc(1'b1, 1'b0, 1'b1, `CAHD_TGT_NONE);
    udma_active <= 1'b1;
    repeat (2) begin
      run <= 1'b1;
      repeat (48) @(posedge ref_clk);
      run <= 1'b0;
      repeat (50) @(posedge ref_clk);
    end
    chk("words", {8'h0, u_cahd_host_model.n}, cnt[15:0]);
    c0 = cnt;
    hold <= 1'b1;
    run <= 1'b1;
    repeat (100) @(posedge ref_clk);
    run <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("overrun", 16'h1, {15'h0, udma_overrun});
    hold <= 1'b0;
    repeat (60) @(posedge ref_clk);
    chk("fill", c0[15:0] + 16'h10, cnt[15:0]);
    io_wr_n <= 1'b0;
    f = 1'b0;
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      f = f | burst_done;
    end
    chk("stop", 16'h1, {15'h0, f});
    io_wr_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    udma_active <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("overrun", 16'h0, {15'h0, udma_overrun});
    {udma_dir_in, udma_active, in_burst_valid, hready} <= 4'hF;
    in_burst_data <= $random(seed);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("burst_rdy", 16'h1, {15'h0, in_burst_ready});
    chk("burst_dat", in_burst_data, data_out);
    hready <= 1'b0;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("burst_rdy", 16'h0, {15'h0, in_burst_ready});
    close_out;
  end
endmodule
